/* File: gpcfg_top.v */
`timescale 1ns/1ns
`include "gpcfg_defs.vh"
// ***********************************************************
// eleven-pin configuration block with axi4-lite registers
// ***********************************************************
module gpcfg_top (
   input  wire        i_clock,                 // core clock, 100 MHz
   input  wire        i_reset,                 // synchronous, active high
   input  wire        i_usb_reset,             // usb reset pulse
   input  wire        i_lite_reset,            // lite reset pulse
   input  wire        i_eeprom_present,        // eeprom detected
   input  wire        i_eeprom_load,           // image load pulse
   input  wire        i_eeprom_led_select,     // led bit from image flags
   input  wire        i_phy_source_select,     // high: external mii in use
   input  wire        i_internal_mii_mirror_enable, // mirror enable from hw config
   input  wire [7:0]  i_low_default_value,     // default function outputs
   input  wire [7:0]  i_low_default_drive,     // default function drive
   input  wire [7:0]  i_low_mirror_value,      // internal mii mirror values
   input  wire        i_mii_rxd2,              // internal receive data bit 2
   input  wire        i_mii_crs,               // internal carrier sense
   input  wire        i_led_speed,             // speed is 100 Mbps
   input  wire        i_led_link,              // link up
   input  wire        i_led_activity,          // traffic seen
   input  wire        i_led_full_duplex,       // full duplex link
   input  wire [10:0] i_pin_in,                // pad levels
   output wire [10:0] o_pin_out,               // pad output values
   output wire [10:0] o_pin_oe_n,              // pad enables, low drives
   output reg         o_led_speed_n,           // speed led, active low
   output reg         o_led_link_act_n,        // link led, active low
   output reg         o_led_third_n,           // duplex or activity led
   input  wire [11:0] i_axi_awaddr,            // write address
   input  wire        i_axi_awvalid,           // write address valid
   output reg         o_axi_awready,           // write address ready
   input  wire [31:0] i_axi_wdata,             // write data
   input  wire [3:0]  i_axi_wstrb,             // write byte strobes
   input  wire        i_axi_wvalid,            // write data valid
   output reg         o_axi_wready,            // write data ready
   output reg  [1:0]  o_axi_bresp,             // write response
   output reg         o_axi_bvalid,            // write response valid
   input  wire        i_axi_bready,            // write response ready
   input  wire [11:0] i_axi_araddr,            // read address
   input  wire        i_axi_arvalid,           // read address valid
   output reg         o_axi_arready,           // read address ready
   output reg  [31:0] o_axi_rdata,             // read data
   output reg  [1:0]  o_axi_rresp,             // read response
   output reg         o_axi_rvalid,            // read data valid
   input  wire        i_axi_rready             // read data ready
);

   // ***********************************************************
   // configuration state
   // ***********************************************************
   reg  [7:0]  low_en_q;       // low_pin_default_enable
   reg  [7:0]  low_buf_q;      // low_pin_buffer_type
   reg  [7:0]  low_dir_q;      // low_pin_direction
   reg  [7:0]  low_data_q;     // low_pin_data, written value
   reg  [1:0]  role8_q;        // pin8_role_select
   reg  [2:0]  high_buf_q;     // high_pin_buffer_type
   reg  [2:0]  high_dir_q;     // high_pin_direction
   reg  [2:0]  high_data_q;    // high_pin_data, written value
   reg         led_map_q;      // led_map_select
   reg         led_image_q;    // last led bit loaded from eeprom
   wire [10:0] pin_level;      // filtered pad levels
   reg  [10:0] drive_w;
   reg  [10:0] value_w;
   reg  [10:0] pp_w;
   reg         led_third_w;
   wire        soft_reset;

   // ***********************************************************
   // bus slave state
   // ***********************************************************
   reg         aw_full_q;
   reg         w_full_q;
   reg  [11:0] aw_addr_q;
   reg  [31:0] w_data_q;
   reg  [3:0]  w_strb_q;
   reg         aw_full_d;
   reg         w_full_d;
   wire        aw_take;
   wire        w_take;
   wire        do_write;
   wire        ar_take;
   wire        hit_high_w;
   wire        hit_low_w;
   reg  [31:0] read_word;
   reg         read_hit;

   assign soft_reset = i_usb_reset | i_lite_reset;

   assign aw_take  = i_axi_awvalid & o_axi_awready;
   assign w_take   = i_axi_wvalid & o_axi_wready;
   assign ar_take  = i_axi_arvalid & o_axi_arready;
   // a write lands once address and data are both held and no answer waits
   assign do_write = aw_full_q & w_full_q & ~o_axi_bvalid;

   assign hit_high_w = (aw_addr_q == `GPCFG_HIGH_CFG_OFS);
   assign hit_low_w  = (aw_addr_q == `GPCFG_LOW_CFG_OFS);

   // ***********************************************************
   // write address and data channels
   // ***********************************************************
   // holding flags; address and data may arrive in either order
   always @* begin
      aw_full_d = aw_full_q;
      w_full_d  = w_full_q;
      if (do_write) begin
         aw_full_d = 1'b0;
         w_full_d  = 1'b0;
      end
      if (aw_take) begin
         aw_full_d = 1'b1;
      end
      if (w_take) begin
         w_full_d = 1'b1;
      end
   end

   // ready is a flop, so it follows the holding flag with no gate in the way
   always @(posedge i_clock) begin
      if (i_reset) begin
         aw_full_q     <= 1'b0;
         w_full_q      <= 1'b0;
         o_axi_awready <= 1'b1;
         o_axi_wready  <= 1'b1;
         aw_addr_q     <= 12'h000;
         w_data_q      <= 32'h0000_0000;
         w_strb_q      <= 4'h0;
      end else begin
         aw_full_q     <= aw_full_d;
         w_full_q      <= w_full_d;
         o_axi_awready <= ~aw_full_d;
         o_axi_wready  <= ~w_full_d;
         if (aw_take) begin
            aw_addr_q <= {i_axi_awaddr[11:2], 2'b00};
         end
         if (w_take) begin
            w_data_q <= i_axi_wdata;
            w_strb_q <= i_axi_wstrb;
         end
      end
   end

   // write response; unmapped addresses answer slverr and change nothing
   always @(posedge i_clock) begin
      if (i_reset) begin
         o_axi_bvalid <= 1'b0;
         o_axi_bresp  <= `GPCFG_RESP_OKAY;
      end else if (do_write) begin
         o_axi_bvalid <= 1'b1;
         o_axi_bresp  <= (hit_high_w | hit_low_w) ? `GPCFG_RESP_OKAY : `GPCFG_RESP_SLVERR;
      end else if (o_axi_bvalid & i_axi_bready) begin
         o_axi_bvalid <= 1'b0;
      end
   end

   // ***********************************************************
   // configuration registers
   // ***********************************************************
   // soft resets clear the pin setup but keep the eeprom led image
   always @(posedge i_clock) begin
      if (i_reset | soft_reset) begin
         low_en_q    <= `GPCFG_LEN_RST;
         low_buf_q   <= `GPCFG_LBUF_RST;
         low_dir_q   <= `GPCFG_LDIR_RST;
         low_data_q  <= 8'h00;
         role8_q     <= `GPCFG_ROLE8_RST;
         high_buf_q  <= `GPCFG_HBUF_RST;
         high_dir_q  <= `GPCFG_HDIR_RST;
         high_data_q <= 3'h0;
      end else if (do_write & hit_low_w) begin
         // reserved bits have no storage, so writes to them vanish
         if (w_strb_q[3]) low_en_q   <= w_data_q[`GPCFG_LEN_LSB +: 8];
         if (w_strb_q[2]) low_buf_q  <= w_data_q[`GPCFG_LBUF_LSB +: 8];
         if (w_strb_q[1]) low_dir_q  <= w_data_q[`GPCFG_LDIR_LSB +: 8];
         if (w_strb_q[0]) low_data_q <= w_data_q[`GPCFG_LDATA_LSB +: 8];
      end else if (do_write & hit_high_w) begin
         if (w_strb_q[2]) role8_q    <= w_data_q[`GPCFG_ROLE8_LSB +: 2];
         if (w_strb_q[1]) high_buf_q <= w_data_q[`GPCFG_HBUF_LSB +: 3];
         if (w_strb_q[0]) begin
            high_dir_q  <= w_data_q[`GPCFG_HDIR_LSB +: 3];
            high_data_q <= w_data_q[`GPCFG_HDATA_LSB +: 3];
         end
      end
   end

   // led select: zero without eeprom, image value after usb or lite reset
   always @(posedge i_clock) begin
      if (i_reset) begin
         led_image_q <= 1'b0;
         led_map_q   <= 1'b0;
      end else if (i_eeprom_load & i_eeprom_present) begin
         led_image_q <= i_eeprom_led_select;
         led_map_q   <= i_eeprom_led_select;
      end else if (soft_reset) begin
         led_map_q <= i_eeprom_present ? led_image_q : 1'b0;
      end else if (do_write & hit_high_w & w_strb_q[3]) begin
         led_map_q <= w_data_q[`GPCFG_LED_MAP_BIT];
      end
   end

   // ***********************************************************
   // read channel
   // ***********************************************************
   // data fields read back the pad levels, not the written values
   always @* begin
      read_word = 32'h0000_0000;
      read_hit  = 1'b1;
      case ({i_axi_araddr[11:2], 2'b00})
         `GPCFG_HIGH_CFG_OFS: begin
            read_word[`GPCFG_LED_MAP_BIT]         = led_map_q;
            read_word[`GPCFG_ROLE8_LSB +: 2]      = role8_q;
            read_word[`GPCFG_HBUF_LSB +: 3]       = high_buf_q;
            read_word[`GPCFG_HDIR_LSB +: 3]       = high_dir_q;
            read_word[`GPCFG_HDATA_LSB +: 3]      = pin_level[10:8];
         end
         `GPCFG_LOW_CFG_OFS: begin
            read_word[`GPCFG_LEN_LSB +: 8]        = low_en_q;
            read_word[`GPCFG_LBUF_LSB +: 8]       = low_buf_q;
            read_word[`GPCFG_LDIR_LSB +: 8]       = low_dir_q;
            read_word[`GPCFG_LDATA_LSB +: 8]      = pin_level[7:0];
         end
         default: begin
            read_hit = 1'b0;
         end
      endcase
   end

   // one read at a time; arready drops while the answer is waiting
   always @(posedge i_clock) begin
      if (i_reset) begin
         o_axi_arready <= 1'b1;
         o_axi_rvalid  <= 1'b0;
         o_axi_rdata   <= 32'h0000_0000;
         o_axi_rresp   <= `GPCFG_RESP_OKAY;
      end else if (ar_take) begin
         o_axi_arready <= 1'b0;
         o_axi_rvalid  <= 1'b1;
         o_axi_rdata   <= read_word;
         o_axi_rresp   <= read_hit ? `GPCFG_RESP_OKAY : `GPCFG_RESP_SLVERR;
      end else if (o_axi_rvalid & i_axi_rready) begin
         o_axi_arready <= 1'b1;
         o_axi_rvalid  <= 1'b0;
      end
   end

   // ***********************************************************
   // led mapping
   // ***********************************************************
   // mapping zero blinks the link led off on traffic, mapping one splits them
   always @(posedge i_clock) begin
      if (i_reset) begin
         o_led_speed_n    <= 1'b1;
         o_led_link_act_n <= 1'b1;
         o_led_third_n    <= 1'b1;
      end else begin
         o_led_speed_n <= ~i_led_speed;
         if (led_map_q) begin
            o_led_link_act_n <= ~i_led_link;
            o_led_third_n    <= ~i_led_activity;
         end else begin
            o_led_link_act_n <= ~(i_led_link & ~i_led_activity);
            o_led_third_n    <= ~i_led_full_duplex;
         end
      end
   end

   // ***********************************************************
   // pin function selection
   // ***********************************************************
   // pin 8 in led role shows the third led function of the current mapping
   always @* begin
      led_third_w = led_map_q ? ~i_led_activity : ~i_led_full_duplex;
   end

   // low pins: external mii or default enable hand the pad to its owner;
   // wake and interrupt sensing lives elsewhere and is only valid for inputs
   integer k;
   always @* begin
      drive_w = 11'h000;
      value_w = 11'h000;
      pp_w    = {high_buf_q, low_buf_q};
      for (k = 0; k < 8; k = k + 1) begin
         if (i_phy_source_select | low_en_q[k]) begin
            drive_w[k] = i_low_default_drive[k];
            value_w[k] = i_low_default_value[k];
         end else if (i_internal_mii_mirror_enable) begin
            drive_w[k] = 1'b1;
            value_w[k] = i_low_mirror_value[k];
         end else begin
            drive_w[k] = low_dir_q[k];
            value_w[k] = low_data_q[k];
         end
      end
      for (k = 9; k < 11; k = k + 1) begin
         drive_w[k] = high_dir_q[k - 8];
         value_w[k] = high_data_q[k - 8];
      end
      case (role8_q)
         `GPCFG_ROLE_GPIO: begin
            drive_w[8] = high_dir_q[0];
            value_w[8] = high_data_q[0];
         end
         `GPCFG_ROLE_LED: begin
            drive_w[8] = 1'b1;
            value_w[8] = led_third_w;
         end
         `GPCFG_ROLE_RXD2: begin
            drive_w[8] = 1'b1;
            value_w[8] = i_mii_rxd2;
         end
         `GPCFG_ROLE_CRS: begin
            drive_w[8] = 1'b1;
            value_w[8] = i_mii_crs;
         end
         default: begin
            drive_w[8] = 1'b0;
            value_w[8] = 1'b0;
         end
      endcase
   end

   // ***********************************************************
   // pad drivers
   // ***********************************************************
   // every pad costs one cycle of output latency for clean registered pins
   genvar g;
   generate
      for (g = 0; g < 11; g = g + 1) begin : g_pin
         gpcfg_pin u_pin (
            .i_clock     (i_clock),
            .i_reset     (i_reset),
            .i_pad       (i_pin_in[g]),
            .i_drive     (drive_w[g]),
            .i_value     (value_w[g]),
            .i_push_pull (pp_w[g]),
            .o_pad_out   (o_pin_out[g]),
            .o_pad_oe_n  (o_pin_oe_n[g]),
            .o_level     (pin_level[g])
         );
      end
   endgenerate

endmodule // gpcfg_top

/* File: gpcfg_defs.vh */
// Overview of operation
// - pin 8 two-bit role selector
// - mirror roles follow internal signal continuously
// - high pin buffer: one push-pull, zero open-drain
// - high pin direction bits 6:4, reset zero
// - high data drives outputs, reads live pins
// - led select restores eeprom image on usb and lite resets
// - pins 0-7 unavailable in external mii mode
// - low enables: one default, reset all ones
// - non-default low pins may mirror mii signals
// - low buffer bits: push-pull or open-drain
// - low direction bits 15:8, reset zero
// - low data drives outputs, reads live pins
// - led select picks two led mappings
`ifndef GPCFG_DEFS_VH
`define GPCFG_DEFS_VH

// ***********************************************************
// register map (byte addresses)
// ***********************************************************
`define GPCFG_ADDR_W         12
`define GPCFG_HIGH_CFG_OFS   12'h024
`define GPCFG_LOW_CFG_OFS    12'h028

// ***********************************************************
// field positions
// ***********************************************************
`define GPCFG_LED_MAP_BIT    31
`define GPCFG_ROLE8_LSB      16
`define GPCFG_HBUF_LSB       8
`define GPCFG_HDIR_LSB       4
`define GPCFG_HDATA_LSB      0
`define GPCFG_LEN_LSB        24
`define GPCFG_LBUF_LSB       16
`define GPCFG_LDIR_LSB       8
`define GPCFG_LDATA_LSB      0

// ***********************************************************
// reset values
// ***********************************************************
`define GPCFG_LEN_RST        8'hFF
`define GPCFG_LBUF_RST       8'h00
`define GPCFG_LDIR_RST       8'h00
`define GPCFG_HBUF_RST       3'h0
`define GPCFG_HDIR_RST       3'h0
`define GPCFG_ROLE8_RST      2'h0

// ***********************************************************
// pin 8 role codes and bus responses
// ***********************************************************
`define GPCFG_ROLE_GPIO      2'h0
`define GPCFG_ROLE_LED       2'h1
`define GPCFG_ROLE_RXD2      2'h2
`define GPCFG_ROLE_CRS       2'h3
`define GPCFG_RESP_OKAY      2'h0
`define GPCFG_RESP_SLVERR    2'h2

`endif

/* File: gpcfg_pin.v */
`timescale 1ns/1ns
// ***********************************************************
// one pad: input filter and registered output driver
// ***********************************************************
module gpcfg_pin (
   input  wire i_clock,      // core clock
   input  wire i_reset,      // synchronous, active high
   input  wire i_pad,        // level seen on the pad
   input  wire i_drive,      // logic wants to drive the pad
   input  wire i_value,      // value to drive
   input  wire i_push_pull,  // one push-pull, zero open-drain
   output reg  o_pad_out,    // pad output value
   output reg  o_pad_oe_n,   // pad output enable, low drives
   output reg  o_level       // filtered pad level
);

   reg s1_q;
   reg s2_q;
   reg s3_q;

   // three-stage synchroniser; first stage feeds only the second
   always @(posedge i_clock) begin
      if (i_reset) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= i_pad;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // level moves only once two stages agree, so one-cycle glitches die here
   always @(posedge i_clock) begin
      if (i_reset) begin
         o_level <= 1'b0;
      end else if (s2_q == s3_q) begin
         o_level <= s3_q;
      end
   end

   // open-drain only ever pulls low; a one releases the pad to its pull-up
   always @(posedge i_clock) begin
      if (i_reset) begin
         o_pad_out  <= 1'b0;
         o_pad_oe_n <= 1'b1;
      end else if (!i_drive) begin
         o_pad_out  <= 1'b0;
         o_pad_oe_n <= 1'b1;
      end else if (i_push_pull) begin
         o_pad_out  <= i_value;
         o_pad_oe_n <= 1'b0;
      end else begin
         o_pad_out  <= 1'b0;
         o_pad_oe_n <= i_value;
      end
   end

endmodule // gpcfg_pin

/* File: gpcfg_props.sv */
`timescale 1ns/1ns
// ***********************************************
// port checker for the pin configuration block
// ***********************************************
module gpcfg_props (
   input wire        i_clock,             // core clock
   input wire        i_reset,             // sync reset
   input wire        i_led_speed,         // speed status
   input wire        i_phy_source_select, // external mii
   input wire [7:0]  i_low_default_drive, // default drive
   input wire [10:0] o_pin_out,           // pad values
   input wire [10:0] o_pin_oe_n,          // pad enables
   input wire        o_led_speed_n,       // speed led
   input wire        o_axi_awready,       // aw ready
   input wire        o_axi_wready,        // w ready
   input wire        o_axi_bvalid,        // b valid
   input wire [1:0]  o_axi_bresp,         // b response
   input wire        i_axi_bready,        // b ready
   input wire [11:0] i_axi_araddr,        // read address
   input wire        i_axi_arvalid,       // ar valid
   input wire        o_axi_arready,       // ar ready
   input wire [31:0] o_axi_rdata,         // read data
   input wire [1:0]  o_axi_rresp,         // read response
   input wire        o_axi_rvalid,        // r valid
   input wire        i_axi_rready         // r ready
);
   // only the two word addresses are mapped, low bits ignored
   wire mapped = (i_axi_araddr[11:2] == 10'h009) || (i_axi_araddr[11:2] == 10'h00A);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);
   reset_idle_a: assert property ($fell(i_reset) |-> o_pin_oe_n == 11'h7FF
      && !o_axi_bvalid && !o_axi_rvalid) else $error("pads or bus busy after reset");
   pad_od_zero_a: assert property ((o_pin_out & o_pin_oe_n) == 11'h000)
      else $error("pad value set while released");
   speed_led_a: assert property (!$past(i_reset) |->
      o_led_speed_n == !$past(i_led_speed)) else $error("speed led wrong");
   ext_mii_idle_a: assert property (i_phy_source_select && $past(i_phy_source_select)
      && i_low_default_drive == 8'h00 && $past(i_low_default_drive) == 8'h00 && !$past(i_reset)
      |-> o_pin_oe_n[7:0] == 8'hFF) else $error("low pad driven in external mii mode");
   write_both_a: assert property ($rose(o_axi_bvalid) |->
      !$past(o_axi_awready) && !$past(o_axi_wready)) else $error("write answered early");
   read_busy_a: assert property (o_axi_rvalid |-> !o_axi_arready)
      else $error("read address taken while answer pending");
   read_answer_a: assert property (i_axi_arvalid && o_axi_arready |=> o_axi_rvalid
      && o_axi_rresp == ($past(mapped) ? 2'h0 : 2'h2)) else $error("read answer wrong");
   unmapped_zero_a: assert property (i_axi_arvalid && o_axi_arready && !mapped |=>
      o_axi_rdata == 32'h00000000) else $error("unmapped read data not zero");
   rvalid_drop_a: assert property (o_axi_rvalid && i_axi_rready |=> !o_axi_rvalid)
      else $error("read answer not released");
   bvalid_drop_a: assert property (o_axi_bvalid && i_axi_bready |=> !o_axi_bvalid)
      else $error("write answer not released");
   cover property (o_axi_bvalid && o_axi_bresp == 2'h2);
   cover property (o_axi_rvalid && o_axi_rresp == 2'h0);
   cover property (!o_pin_oe_n[8] && o_pin_out[8]);
endmodule // gpcfg_props

/* File: gpcfg_pads.sv */
`timescale 1ns/1ns
// ***********************************************
// far side: pull-up pads with optional driver
// ***********************************************
module gpcfg_pads (
   input  wire [10:0] i_pin_out,  // values from block
   input  wire [10:0] i_pin_oe_n, // low: block drives
   input  wire [10:0] i_ext_en,   // far side drives
   input  wire [10:0] i_ext_val,  // far side value
   output wire [10:0] o_level     // resolved level
);
   // released pads pull up so open-drain ones read back high
   assign o_level = (~i_pin_oe_n & i_pin_out)
      | (i_pin_oe_n & ((i_ext_en & i_ext_val) | ~i_ext_en));
endmodule // gpcfg_pads

/* File: test_gpio_pin_config_block.sv */
`timescale 1ns/1ns
// ***********************************************
// register level test of the pin block
// ***********************************************
module test_gpio_pin_config_block;
   reg         clk = 1'b0, rst = 1'b1, usb = 1'b0, lite = 1'b0, eep = 1'b0, eld = 1'b0;
   reg         esel = 1'b0, phy = 1'b0, mirr = 1'b0, rxd2 = 1'b0, crs = 1'b0;
   reg         spd = 1'b0, lnk = 1'b0, act = 1'b0, fdx = 1'b0, e;
   reg  [7:0]  dval = 8'h00, ddrv = 8'h00, mval = 8'h00;
   reg  [10:0] ext_en = 11'h000, ext_val = 11'h000;
   reg  [11:0] awaddr = 12'h000, araddr = 12'h000;
   reg  [31:0] wdata = 32'h00000000;
   reg  [3:0]  strb = 4'hF;
   reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   wire [10:0] pin_in, pout, poe_n;
   wire        led_s, led_l, led_t, awready, wready, bvalid, arready, rvalid;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata;
   integer     num_errors = 0, n_compared = 0, i, s;
   initial forever #5 clk = ~clk;
   gpcfg_top dut (.i_clock(clk), .i_reset(rst), .i_usb_reset(usb), .i_lite_reset(lite),
      .i_eeprom_present(eep), .i_eeprom_load(eld), .i_eeprom_led_select(esel),
      .i_phy_source_select(phy), .i_internal_mii_mirror_enable(mirr),
      .i_low_default_value(dval), .i_low_default_drive(ddrv), .i_low_mirror_value(mval),
      .i_mii_rxd2(rxd2), .i_mii_crs(crs), .i_led_speed(spd), .i_led_link(lnk),
      .i_led_activity(act), .i_led_full_duplex(fdx), .i_pin_in(pin_in), .o_pin_out(pout),
      .o_pin_oe_n(poe_n), .o_led_speed_n(led_s), .o_led_link_act_n(led_l),
      .o_led_third_n(led_t), .i_axi_awaddr(awaddr), .i_axi_awvalid(awvalid),
      .o_axi_awready(awready), .i_axi_wdata(wdata), .i_axi_wstrb(strb),
      .i_axi_wvalid(wvalid), .o_axi_wready(wready), .o_axi_bresp(bresp),
      .o_axi_bvalid(bvalid), .i_axi_bready(bready), .i_axi_araddr(araddr),
      .i_axi_arvalid(arvalid), .o_axi_arready(arready), .o_axi_rdata(rdata),
      .o_axi_rresp(rresp), .o_axi_rvalid(rvalid), .i_axi_rready(rready));
   gpcfg_pads pads (.i_pin_out(pout), .i_pin_oe_n(poe_n), .i_ext_en(ext_en),
      .i_ext_val(ext_val), .o_level(pin_in));
   // one counted comparison
   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task results;
      begin
         if (num_errors == 0 && n_compared > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   // write: both channels offered, each dropped once taken
   task wr(input [11:0] a, input [31:0] d, input [1:0] er);
      integer k;
      begin
         @(posedge clk);
         awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
         for (k = 0; k < 40; k = k + 1) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) k = 99;
         end
         if (k != 100) begin num_errors = num_errors + 1; results; end
         chk({30'h0, bresp}, {30'h0, er});
         bready <= 1'b0;
      end
   endtask
   task rd(input [11:0] a, input [31:0] ex, input [1:0] er);
      integer k;
      begin
         @(posedge clk);
         araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
         for (k = 0; k < 40; k = k + 1) begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) k = 99;
         end
         if (k != 100) begin num_errors = num_errors + 1; results; end
         chk(rdata, ex);
         chk({30'h0, rresp}, {30'h0, er});
         rready <= 1'b0;
      end
   endtask
   // pad path: output flop plus input synchroniser
   task settle;
      repeat (8) @(posedge clk);
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      settle;
      rd(12'h028, 32'hFF0000FF, 2'h0);
      rd(12'h024, 32'h00000007, 2'h0);
      wr(12'h024, 32'hFFFFFFFF, 2'h0);
      settle;
      rd(12'h024, 32'h80030776, 2'h0);
      // every role against four input patterns
      for (s = 0; s < 4; s = s + 1)
         for (i = 0; i < 4; i = i + 1) begin
            act <= !s[1]; rxd2 <= s[0] ^ s[1]; crs <= !s[0];
            wr(12'h024, 32'h80000110 | (i << 16) | s[0], 2'h0);
            settle;
            e = (i == 0) ? s[0] : (i == 1) ? s[1] : (i == 2) ? s[0] ^ s[1] : !s[0];
            chk({30'h0, pout[8], poe_n[8]}, {30'h0, e, 1'b0});
         end
      wr(12'h024, 32'h00000020, 2'h0);
      settle;
      chk({30'h0, pout[9], poe_n[9]}, 32'h0);
      wr(12'h024, 32'h00000022, 2'h0);
      settle;
      chk({30'h0, pout[9], poe_n[9]}, 32'h1);
      wr(12'h028, 32'h000FFFA5, 2'h0);
      settle;
      chk({16'h0, pout[7:0], poe_n[7:0]}, 32'h05A0);
      rd(12'h028, 32'h000FFFA5, 2'h0);
      ext_en <= 11'h0FF; ext_val <= 11'h03C;
      wr(12'h028, 32'h00000000, 2'h0);
      settle;
      rd(12'h028, 32'h0000003C, 2'h0);
      mirr <= 1'b1; mval <= 8'h5A; ext_en <= 11'h000;
      wr(12'h028, 32'h00FF0000, 2'h0);
      settle;
      chk({24'h0, pout[7:0]}, 32'h5A);
      phy <= 1'b1;
      settle;
      ddrv <= 8'hFF; dval <= 8'h33;
      settle;
      rd(12'h028, 32'h00FF0033, 2'h0);
      phy <= 1'b0; mirr <= 1'b0; dval <= 8'h0F;
      wr(12'h028, 32'hFF000000, 2'h0);
      settle;
      rd(12'h028, 32'hFF00000F, 2'h0);
      ddrv <= 8'h00; eep <= 1'b1; esel <= 1'b1; eld <= 1'b1;
      spd <= 1'b1; lnk <= 1'b1; act <= 1'b1; fdx <= 1'b0;
      @(posedge clk);
      eld <= 1'b0;
      settle;
      rd(12'h024, 32'h80000027, 2'h0);
      chk({29'h0, led_s, led_l, led_t}, 32'h0);
      wr(12'h024, 32'h00000000, 2'h0);
      settle;
      chk({29'h0, led_s, led_l, led_t}, 32'h3);
      lite <= 1'b1;
      settle;
      lite <= 1'b0;
      rd(12'h024, 32'h80000007, 2'h0);
      wr(12'h024, 32'h00000000, 2'h0);
      usb <= 1'b1;
      @(posedge clk);
      usb <= 1'b0;
      settle;
      rd(12'h024, 32'h80000007, 2'h0);
      eep <= 1'b0; usb <= 1'b1; strb <= 4'h2;
      @(posedge clk);
      usb <= 1'b0;
      settle;
      wr(12'h024, 32'hFFFFFFFF, 2'h0);
      rd(12'h024, 32'h00000707, 2'h0);
      wr(12'h030, 32'hFFFFFFFF, 2'h2);
      rd(12'h030, 32'h00000000, 2'h2);
      // mid-run reset restores defaults
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      settle;
      rd(12'h028, 32'hFF0000FF, 2'h0);
      results;
   end
endmodule // test_gpio_pin_config_block
bind gpcfg_top gpcfg_props props (.i_clock(i_clock), .i_reset(i_reset),
   .i_led_speed(i_led_speed), .i_phy_source_select(i_phy_source_select),
   .i_low_default_drive(i_low_default_drive), .o_pin_out(o_pin_out),
   .o_pin_oe_n(o_pin_oe_n), .o_led_speed_n(o_led_speed_n), .o_axi_awready(o_axi_awready),
   .o_axi_wready(o_axi_wready), .o_axi_bvalid(o_axi_bvalid), .o_axi_bresp(o_axi_bresp),
   .i_axi_bready(i_axi_bready), .i_axi_araddr(i_axi_araddr), .i_axi_arvalid(i_axi_arvalid),
   .o_axi_arready(o_axi_arready), .o_axi_rdata(o_axi_rdata), .o_axi_rresp(o_axi_rresp),
   .o_axi_rvalid(o_axi_rvalid), .i_axi_rready(i_axi_rready));
